// >>> asl_pkg.sv
// asl_pkg: constants, opcodes and states for the accumulator/stack load unit
// assumes one clock domain; the sequencer issues one operation at a time
// Functional notes
// RQ1: 32-bit accumulator, cleared at every scan end
// RQ2: manipulation result replaces accumulator operand
// RQ3: first load writes only; later loads push
// RQ4: load after output overwrites without pushing
// RQ5: eight-deep stack; push drops deepest entry
// RQ6: pop takes top entry, shifts stack up
// RQ7: pop fills vacated deepest entry with zero
// RQ8: pointer word is hex address of operand
// RQ9: word load fills low half, zeroes upper
// RQ10: double load fills all 32 bits
// RQ11: lower address word goes to low half
// RQ12: double add sums; double output writes two words
// RQ13: output copies low 16 bits to memory
// RQ14: bit-field load gathers 1-32 bits, clears rest
// RQ15: start bit lands in accumulator bit 0
// RQ16: octal operand converted to hex, loaded
// RQ17: pointer beyond memory sets pointer-range flag
// RQ18: load sets negative flag from msb
// RQ19: load of zero sets zero-load flag
// RQ20: indexed load adds top stack entry to base
package asl_pkg;
	localparam int ACC_W     = 32;
	localparam int WORD_W    = 16;
	localparam int STACK_D   = 8;
	localparam int ADDR_W    = 16;
	localparam int DADDR_W   = 16;
	localparam int FLEN_W    = 6;
	localparam int OCT_DIGITS = 5;
	localparam logic [ACC_W-1:0]  ACC_RST = 32'h0000_0000;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
	localparam logic [DADDR_W-1:0] DADDR_ONE = 16'h0001;
	localparam logic [FLEN_W-1:0] FLEN_ONE = 6'h01;

	typedef enum logic [3:0]
	{
		ASL_OP_LOAD_WORD          = 4'h0,
		ASL_OP_LOAD_DOUBLE_WORD   = 4'h1,
		ASL_OP_LOAD_BIT_FIELD     = 4'h2,
		ASL_OP_LOAD_OCTAL_ADDRESS = 4'h3,
		ASL_OP_LOAD_INDEXED_WORD  = 4'h4,
		ASL_OP_OUT_WORD           = 4'h5,
		ASL_OP_OUT_DOUBLE_WORD    = 4'h6,
		ASL_OP_ADD_DOUBLE_WORD    = 4'h7,
		ASL_OP_POP                = 4'h8
	} asl_op_t;

	typedef enum logic [1:0]
	{
		ASL_SRC_MEM   = 2'h0,
		ASL_SRC_CONST = 2'h1,
		ASL_SRC_PTR   = 2'h2
	} asl_src_t;

	typedef enum logic [2:0]
	{
		ASL_ST_IDLE  = 3'h0,
		ASL_ST_PTR   = 3'h1,
		ASL_ST_LO    = 3'h2,
		ASL_ST_HI    = 3'h3,
		ASL_ST_BITS  = 3'h4,
		ASL_ST_WR_LO = 3'h5,
		ASL_ST_WR_HI = 3'h6,
		ASL_ST_DONE  = 3'h7
	} asl_state_t;
endpackage

// >>> asl_stack.sv
// asl_stack: eight-entry push-down store for the accumulator unit
// assumes push and pop are never asserted together
`timescale 1ns/1ps
module asl_stack
	import asl_pkg::*;
#(
	parameter int DEPTH = asl_pkg::STACK_D,
	parameter int W     = asl_pkg::ACC_W
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         clear_i,
	input  wire logic         push_i,
	input  wire logic         pop_i,
	input  wire logic [W-1:0] push_data_i,
	output logic      [W-1:0] top_o
);
	logic [W-1:0] entry [DEPTH];

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				entry[i] <= '0;
		end
		else if (clear_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				entry[i] <= '0;
		end
		else if (push_i)
		begin
			// deepest entry falls off and is lost
			for (int i = DEPTH-1; i > 0; i--)
				entry[i] <= entry[i-1]; // RQ5
			entry[0] <= push_data_i;
		end
		else if (pop_i)
		begin
			for (int i = 0; i < DEPTH-1; i++)
				entry[i] <= entry[i+1]; // RQ6
			entry[DEPTH-1] <= '0; // RQ7
		end
	end

	// combinational top copy so the unit sees entry 0 straight from its flip-flop
	always_comb top_o = entry[0];
endmodule

// >>> asl_unit.sv
// asl_unit: accumulator, stack and load/output sequencing of a scan-based controller
// assumes the sequencer holds op fields stable while start_i pulses and waits for done_o;
// word memory answers a read in the same cycle while mem_rd_o stands, discrete memory likewise
`timescale 1ns/1ps
module asl_unit
	import asl_pkg::*;
#(
	parameter int MEM_WORDS = 4096
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   scan_end_i,
	input  wire logic                   start_i,
	input  wire asl_pkg::asl_op_t       op_i,
	input  wire asl_pkg::asl_src_t      src_i,
	input  wire logic [asl_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [asl_pkg::ACC_W-1:0]   const_i,
	input  wire logic [asl_pkg::DADDR_W-1:0] bit_addr_i,
	input  wire logic [asl_pkg::FLEN_W-1:0]  bit_count_i,
	input  wire logic [asl_pkg::WORD_W-1:0]  mem_rdata_i,
	input  wire logic                   bit_rdata_i,
	output logic                        done_o,
	output logic [asl_pkg::ACC_W-1:0]   acc_o,
	output logic [asl_pkg::ACC_W-1:0]   stack_top_o,
	output logic                        mem_rd_o,
	output logic                        mem_wr_o,
	output logic [asl_pkg::ADDR_W-1:0]  mem_addr_o,
	output logic [asl_pkg::WORD_W-1:0]  mem_wdata_o,
	output logic                        bit_rd_o,
	output logic [asl_pkg::DADDR_W-1:0] bit_addr_o,
	output logic                        pointer_range_flag_o,
	output logic                        negative_flag_o,
	output logic                        zero_load_flag_o
);
	import asl_pkg::*;

	asl_state_t             state;
	asl_op_t                op;
	logic [ACC_W-1:0]       acc;
	logic [ACC_W-1:0]       load_val;
	logic [ADDR_W-1:0]      addr;
	logic [FLEN_W-1:0]      bits_left;
	logic [FLEN_W-1:0]      bit_pos;
	logic                   loaded_since_out;
	logic                   wait_rd;
	logic                   push;
	logic                   pop;
	logic                   finish_load;
	logic [ACC_W-1:0]       stack_top;

	// octal digits packed in hex nibbles to their binary value
	function automatic logic [ACC_W-1:0] oct_to_hex(input logic [ACC_W-1:0] v);
		logic [ACC_W-1:0] r;
		r = '0;
		for (int i = OCT_DIGITS-1; i >= 0; i--)
			r = (r << 3) | ACC_W'(v[i*4 +: 3]);
		return r;
	endfunction

	function automatic logic in_range(input logic [ADDR_W-1:0] a);
		return 32'(a) < MEM_WORDS;
	endfunction

	asl_stack #(
		.DEPTH (STACK_D),
		.W     (ACC_W)
	) u_stack (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.clear_i     (scan_end_i),
		.push_i      (push),
		.pop_i       (pop),
		.push_data_i (acc),
		.top_o       (stack_top)
	);

	// push only when a prior load in this scan was not consumed by an output
	always_comb
	begin
		push = 1'b0;
		pop  = 1'b0;
		if (start_i && state == ASL_ST_IDLE && !scan_end_i)
		begin
			if (op_i == ASL_OP_POP)
				pop = 1'b1; // RQ6
			else if (op_i <= ASL_OP_LOAD_INDEXED_WORD && loaded_since_out)
				push = 1'b1; // RQ3
		end
	end

	// sequencing of memory transactions
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state      <= ASL_ST_IDLE;
			op         <= ASL_OP_LOAD_WORD;
			addr       <= '0;
			bits_left  <= '0;
			bit_pos    <= '0;
			wait_rd    <= 1'b0;
			mem_rd_o   <= 1'b0;
			mem_wr_o   <= 1'b0;
			mem_addr_o <= '0;
			mem_wdata_o <= '0;
			bit_rd_o   <= 1'b0;
			bit_addr_o <= '0;
			done_o     <= 1'b0;
		end
		else
		begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			bit_rd_o <= 1'b0;
			done_o   <= 1'b0;
			unique case (state)
				ASL_ST_IDLE:
				begin
					wait_rd <= 1'b0;
					if (start_i && !scan_end_i)
					begin
						op <= op_i;
						unique case (op_i)
							ASL_OP_LOAD_WORD, ASL_OP_LOAD_DOUBLE_WORD, ASL_OP_ADD_DOUBLE_WORD:
							begin
								if (op_i != ASL_OP_ADD_DOUBLE_WORD && src_i == ASL_SRC_CONST)
									state <= ASL_ST_DONE;
								else
								begin
									mem_rd_o   <= 1'b1;
									mem_addr_o <= addr_i;
									state <= (src_i == ASL_SRC_PTR) ? ASL_ST_PTR : ASL_ST_LO; // RQ8
								end
							end
							ASL_OP_LOAD_INDEXED_WORD:
							begin
								mem_rd_o   <= 1'b1;
								// a push in this same edge makes the accumulator the new top entry
								mem_addr_o <= addr_i + (push ? acc[ADDR_W-1:0] : stack_top[ADDR_W-1:0]); // RQ20
								state      <= ASL_ST_LO;
							end
							ASL_OP_LOAD_BIT_FIELD:
							begin
								bits_left  <= bit_count_i;
								bit_pos    <= '0;
								bit_rd_o   <= 1'b1;
								bit_addr_o <= bit_addr_i; // RQ15
								state      <= ASL_ST_BITS;
							end
							ASL_OP_OUT_WORD, ASL_OP_OUT_DOUBLE_WORD:
							begin
								mem_wr_o    <= 1'b1;
								mem_addr_o  <= addr_i;
								mem_wdata_o <= acc[WORD_W-1:0]; // RQ13
								state <= (op_i == ASL_OP_OUT_DOUBLE_WORD) ? ASL_ST_WR_HI : ASL_ST_DONE;
							end
							default:
								state <= ASL_ST_DONE;
						endcase
					end
				end
				ASL_ST_PTR:
				begin
					// pointer word is read as a hex word address
					addr       <= mem_rdata_i; // RQ8
					mem_rd_o   <= in_range(mem_rdata_i);
					mem_addr_o <= mem_rdata_i;
					state      <= ASL_ST_LO;
				end
				ASL_ST_LO:
				begin
					if (op == ASL_OP_LOAD_WORD || op == ASL_OP_LOAD_INDEXED_WORD)
						state <= ASL_ST_DONE;
					else
					begin
						mem_rd_o   <= 1'b1;
						mem_addr_o <= mem_addr_o + ADDR_ONE; // RQ11
						state      <= ASL_ST_HI;
					end
				end
				ASL_ST_HI:
					state <= ASL_ST_DONE;
				ASL_ST_BITS:
				begin
					bit_pos <= bit_pos + FLEN_ONE;
					if (bits_left == FLEN_ONE)
						state <= ASL_ST_DONE;
					else
					begin
						bits_left  <= bits_left - FLEN_ONE;
						bit_rd_o   <= 1'b1;
						bit_addr_o <= bit_addr_o + DADDR_ONE;
					end
				end
				ASL_ST_WR_HI:
				begin
					mem_wr_o    <= 1'b1;
					mem_addr_o  <= mem_addr_o + ADDR_ONE;
					mem_wdata_o <= acc[ACC_W-1:WORD_W]; // RQ12
					state       <= ASL_ST_DONE;
				end
				ASL_ST_WR_LO:
					state <= ASL_ST_DONE;
				ASL_ST_DONE:
				begin
					done_o <= 1'b1;
					state  <= ASL_ST_IDLE;
				end
			endcase
			if (scan_end_i)
				state <= ASL_ST_IDLE;
		end
	end

	// pointer range check on the indirect word/double loads
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			pointer_range_flag_o <= 1'b0;
		else if (state == ASL_ST_PTR)
			pointer_range_flag_o <= !in_range(mem_rdata_i) ||
				(op != ASL_OP_LOAD_WORD && !in_range(mem_rdata_i + ADDR_ONE)); // RQ17
	end

	// gather load value; memory data arrives while each registered read strobe stands
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			load_val <= '0;
		else if (state == ASL_ST_IDLE && start_i)
		begin
			unique case (op_i)
				ASL_OP_LOAD_WORD:          load_val <= {WORD_ZERO, const_i[WORD_W-1:0]}; // RQ9
				ASL_OP_LOAD_DOUBLE_WORD:   load_val <= const_i; // RQ10
				ASL_OP_LOAD_OCTAL_ADDRESS: load_val <= {WORD_ZERO, oct_to_hex(const_i)[WORD_W-1:0]}; // RQ16
				default:                   load_val <= '0; // RQ14
			endcase
		end
		else if (state == ASL_ST_LO)
			load_val <= {WORD_ZERO, mem_rdata_i}; // RQ9
		else if (state == ASL_ST_HI)
			load_val[ACC_W-1:WORD_W] <= mem_rdata_i; // RQ11
		else if (state == ASL_ST_BITS)
			load_val[bit_pos[FLEN_W-2:0]] <= bit_rdata_i; // RQ14
	end

	// finishing a load commits load_val to the accumulator; an add commits acc + load_val
	assign finish_load = (state == ASL_ST_DONE) && (op <= ASL_OP_LOAD_INDEXED_WORD);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			acc <= ACC_RST;
		else if (scan_end_i)
			acc <= ACC_RST; // RQ1
		else if (pop)
			acc <= stack_top; // RQ6
		else if (finish_load)
			acc <= (op == ASL_OP_LOAD_WORD && pointer_range_flag_o && wait_rd) ? acc : load_val; // RQ2
		else if (state == ASL_ST_DONE && op == ASL_OP_ADD_DOUBLE_WORD)
			acc <= acc + load_val; // RQ12
	end

	// load/out history for push decisions
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			loaded_since_out <= 1'b0;
		else if (scan_end_i)
			loaded_since_out <= 1'b0; // RQ1
		else if (state == ASL_ST_IDLE && start_i)
		begin
			if (op_i <= ASL_OP_LOAD_INDEXED_WORD)
				loaded_since_out <= 1'b1; // RQ3
			else if (op_i == ASL_OP_OUT_WORD || op_i == ASL_OP_OUT_DOUBLE_WORD)
				loaded_since_out <= 1'b0; // RQ4
		end
	end

	// flags follow the value written by a load
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			negative_flag_o  <= 1'b0;
			zero_load_flag_o <= 1'b0;
		end
		else if (finish_load)
		begin
			negative_flag_o  <= load_val[ACC_W-1]; // RQ18
			zero_load_flag_o <= (load_val == ACC_RST); // RQ19
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc_o       <= ACC_RST;
			stack_top_o <= ACC_RST;
		end
		else
		begin
			acc_o       <= acc;
			stack_top_o <= stack_top;
		end
	end
endmodule

// >>> asl_mem_model.sv
// word and discrete memory seen by asl_unit
// answers while the registered read strobe stands, so the unit samples it at the next edge;
// outside a read the data lines toggle to expose late sampling
`timescale 1ns/1ps
module asl_mem_model
	import asl_pkg::*;
(
	input  wire logic                         clk_i,
	input  wire logic                         mem_rd_i,
	input  wire logic                         mem_wr_i,
	input  wire logic [asl_pkg::ADDR_W-1:0]  mem_addr_i,
	input  wire logic [asl_pkg::WORD_W-1:0]  mem_wdata_i,
	input  wire logic                         bit_rd_i,
	input  wire logic [asl_pkg::DADDR_W-1:0] bit_addr_i,
	output logic      [asl_pkg::WORD_W-1:0]  mem_rdata_o,
	output logic                              bit_rdata_o
);
	logic [WORD_W-1:0] mem [0:65535];
	logic [WORD_W-1:0] held_word = 16'h0000;
	logic              held_bit  = 1'b0;
	assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~held_word;
	assign bit_rdata_o = bit_rd_i ? (bit_addr_i[0] ^ bit_addr_i[2]) : ~held_bit;
	always @(posedge clk_i)
	begin
		if (mem_wr_i)
			mem[mem_addr_i] <= mem_wdata_i;
		held_word <= mem_rdata_o;
		held_bit  <= bit_rdata_o;
	end
endmodule

// >>> asl_unit_properties.sv
// port timing checker for asl_unit
// bound to every asl_unit instance
`timescale 1ns/1ps
module asl_unit_properties
	import asl_pkg::*;
#(
	parameter int MEM_WORDS = 4096
)
(
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                scan_end_i,
	input wire logic                start_i,
	input wire asl_pkg::asl_op_t    op_i,
	input wire asl_pkg::asl_src_t   src_i,
	input wire logic [15:0]         addr_i,
	input wire logic [31:0]         const_i,
	input wire logic [15:0]         bit_addr_i,
	input wire logic                done_o,
	input wire logic [31:0]         acc_o,
	input wire logic [31:0]         stack_top_o,
	input wire logic                mem_wr_o,
	input wire logic                mem_rd_o,
	input wire logic [15:0]         mem_addr_o,
	input wire logic [15:0]         mem_wdata_o,
	input wire logic                bit_rd_o,
	input wire logic [15:0]         bit_addr_o,
	input wire logic                negative_flag_o,
	input wire logic                zero_load_flag_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic        busy;
	logic        taken;
	logic [31:0] cap_c;
	asl_op_t     last_op;
	assign taken = start_i && !busy && !scan_end_i;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			busy <= 1'b0;
		else if (scan_end_i || done_o)
			busy <= 1'b0;
		else if (start_i)
			busy <= 1'b1;
	end
	// capture so later operand changes do not disturb the check
	always_ff @(posedge clk_i)
	begin
		if (taken)
		begin
			cap_c <= const_i;
			last_op <= op_i;
		end
	end
	AST_SCAN_CLEAR: assert property (scan_end_i |=> ##1 (acc_o == 32'h0 && stack_top_o == 32'h0))
		else $error("scan end did not clear");
	AST_WORD_CONST: assert property (taken && op_i == ASL_OP_LOAD_WORD && src_i == ASL_SRC_CONST
		|-> ##2 done_o ##1 acc_o == {16'h0000, cap_c[15:0]}) else $error("word const load wrong");
	AST_WORD_MEM: assert property (taken && op_i == ASL_OP_LOAD_WORD && src_i == ASL_SRC_MEM
		|=> mem_rd_o && mem_addr_o == $past(addr_i) ##2 done_o) else $error("word mem read wrong");
	AST_DBL_CONST: assert property (taken && op_i == ASL_OP_LOAD_DOUBLE_WORD && src_i == ASL_SRC_CONST
		|-> ##2 done_o ##1 acc_o == cap_c) else $error("double const load wrong");
	AST_OCTAL: assert property (taken && op_i == ASL_OP_LOAD_OCTAL_ADDRESS |-> ##2 done_o ##1
		acc_o == {17'h0, cap_c[18:16], cap_c[14:12], cap_c[10:8], cap_c[6:4], cap_c[2:0]})
		else $error("octal conversion wrong");
	AST_POP: assert property (taken && op_i == ASL_OP_POP |-> ##2 done_o ##1 acc_o == $past(stack_top_o, 3))
		else $error("pop did not take top entry");
	AST_FLAGS: assert property (done_o && last_op <= ASL_OP_LOAD_INDEXED_WORD |=>
		negative_flag_o == acc_o[31] && zero_load_flag_o == (acc_o == 32'h0)) else $error("load flags wrong");
	AST_OUT_WORD: assert property (taken && op_i == ASL_OP_OUT_WORD |->
		##[1:2] (mem_wr_o && mem_wdata_o == acc_o[15:0])) else $error("out word data wrong");
	AST_BITS: assert property (taken && op_i == ASL_OP_LOAD_BIT_FIELD |=>
		bit_rd_o && bit_addr_o == $past(bit_addr_i)) else $error("bit field start wrong");
	cover property (taken && op_i == ASL_OP_POP);
	cover property (taken && op_i == ASL_OP_LOAD_BIT_FIELD);
	cover property (scan_end_i);
endmodule
bind asl_unit asl_unit_properties #(.MEM_WORDS(MEM_WORDS)) u_props (.clk_i, .rst_i, .scan_end_i, .start_i,
	.op_i, .src_i, .addr_i, .const_i, .bit_addr_i, .done_o, .acc_o, .stack_top_o, .mem_wr_o, .mem_rd_o,
	.mem_addr_o, .mem_wdata_o, .bit_rd_o, .bit_addr_o, .negative_flag_o, .zero_load_flag_o);

// >>> testbench.sv
// self-checking bench for asl_unit with memory model
// inputs change on falling edges; one operation in flight
`timescale 1ns/1ps
module testbench;
	import asl_pkg::*;
	logic        clk_i, rst_i, scan_end_i, start_i, bit_rdata_i, done_o, mem_rd_o, mem_wr_o, bit_rd_o;
	logic        pointer_range_flag_o, negative_flag_o, zero_load_flag_o;
	asl_op_t     op_i;
	asl_src_t    src_i;
	logic [15:0] addr_i, bit_addr_i, mem_rdata_i, mem_addr_o, mem_wdata_o, bit_addr_o;
	logic [31:0] const_i, acc_o, stack_top_o;
	logic [5:0]  bit_count_i;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	asl_unit DUT (.clk_i, .rst_i, .scan_end_i, .start_i, .op_i, .src_i, .addr_i, .const_i, .bit_addr_i,
		.bit_count_i, .mem_rdata_i, .bit_rdata_i, .done_o, .acc_o, .stack_top_o, .mem_rd_o, .mem_wr_o,
		.mem_addr_o, .mem_wdata_o, .bit_rd_o, .bit_addr_o, .pointer_range_flag_o, .negative_flag_o,
		.zero_load_flag_o);
	asl_mem_model MDL (.clk_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .bit_rd_i(bit_rd_o), .bit_addr_i(bit_addr_o), .mem_rdata_o(mem_rdata_i),
		.bit_rdata_o(bit_rdata_i));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// entered on a falling edge; returns once acc_o shows the result
	task automatic run(input asl_op_t o, input asl_src_t s, input logic [31:0] v,
		input logic [15:0] ba = 16'h0, input logic [5:0] bc = 6'h1);
		int n;
		op_i = o;
		src_i = s;
		addr_i = v[15:0];
		const_i = v;
		bit_addr_i = ba;
		bit_count_i = bc;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 60)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n == 60)
		begin
			n_mismatch++;
			$display("unexpected at %0t: no done", $time);
			summarize();
		end
		@(negedge clk_i);
	endtask
	task automatic clr();
		scan_end_i = 1'b1;
		@(negedge clk_i);
		scan_end_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk(acc_o, 32'h0);
		chk(stack_top_o, 32'h0);
	endtask
	function automatic logic [31:0] bexp(input logic [15:0] a, input int c);
		logic [15:0] ai;
		bexp = 32'h0;
		for (int i = 0; i < c; i++)
		begin
			ai = a + 16'(i);
			bexp[i] = ai[0] ^ ai[2];
		end
	endfunction
	task automatic t_load_push();
		clr();
		run(ASL_OP_LOAD_WORD, ASL_SRC_CONST, 32'h1234_abcd);
		chk(acc_o, 32'h0000_abcd);
		chk(stack_top_o, 32'h0);
		chk({30'h0, negative_flag_o, zero_load_flag_o}, 32'h0);
		run(ASL_OP_LOAD_DOUBLE_WORD, ASL_SRC_CONST, 32'h8000_0001);
		chk(acc_o, 32'h8000_0001);
		chk(stack_top_o, 32'h0000_abcd);
		chk({30'h0, negative_flag_o, zero_load_flag_o}, 32'h2);
		$display("load_push done");
	endtask
	task automatic t_out();
		clr();
		run(ASL_OP_LOAD_WORD, ASL_SRC_CONST, 32'h7);
		run(ASL_OP_LOAD_WORD, ASL_SRC_CONST, 32'h5);
		run(ASL_OP_OUT_WORD, ASL_SRC_MEM, 32'h0100);
		chk({16'h0, MDL.mem[16'h0100]}, 32'h5);
		run(ASL_OP_LOAD_WORD, ASL_SRC_CONST, 32'h0);
		chk(stack_top_o, 32'h7);
		chk({30'h0, negative_flag_o, zero_load_flag_o}, 32'h1);
		$display("out done");
	endtask
	task automatic t_double();
		MDL.mem[16'h0200] = 16'h1111;
		MDL.mem[16'h0201] = 16'h8222;
		clr();
		run(ASL_OP_LOAD_DOUBLE_WORD, ASL_SRC_MEM, 32'h0200);
		chk(acc_o, 32'h8222_1111);
		run(ASL_OP_ADD_DOUBLE_WORD, ASL_SRC_MEM, 32'h0200);
		chk(acc_o, 32'h0444_2222);
		run(ASL_OP_OUT_DOUBLE_WORD, ASL_SRC_MEM, 32'h0300);
		chk({MDL.mem[16'h0301], MDL.mem[16'h0300]}, 32'h0444_2222);
		$display("double done");
	endtask
	task automatic t_ptr();
		MDL.mem[16'h0010] = 16'h0120;
		MDL.mem[16'h0011] = 16'h2000;
		MDL.mem[16'h0120] = 16'hbeef;
		clr();
		run(ASL_OP_LOAD_WORD, ASL_SRC_PTR, 32'h0010);
		chk(acc_o, 32'h0000_beef);
		chk({31'h0, pointer_range_flag_o}, 32'h0);
		run(ASL_OP_LOAD_WORD, ASL_SRC_PTR, 32'h0011);
		chk({31'h0, pointer_range_flag_o}, 32'h1);
		MDL.mem[16'h0125] = 16'h00c3;
		clr();
		run(ASL_OP_LOAD_WORD, ASL_SRC_CONST, 32'h0005);
		run(ASL_OP_LOAD_INDEXED_WORD, ASL_SRC_MEM, 32'h0120);
		chk(acc_o, 32'h0000_00c3);
		chk(stack_top_o, 32'h0000_0005);
		$display("pointer done");
	endtask
	task automatic t_bits_octal();
		int cs[3] = '{1, 7, 32};
		foreach (cs[i])
		begin
			clr();
			run(ASL_OP_LOAD_BIT_FIELD, ASL_SRC_MEM, 32'h0, 16'h0003, 6'(cs[i]));
			chk(acc_o, bexp(16'h0003, cs[i]));
		end
		run(ASL_OP_LOAD_OCTAL_ADDRESS, ASL_SRC_CONST, 32'h0004_0400);
		chk(acc_o, 32'h0000_4100);
		run(ASL_OP_LOAD_OCTAL_ADDRESS, ASL_SRC_CONST, 32'h0007_7777);
		chk(acc_o, 32'h0000_7fff);
		$display("bits_octal done");
	endtask
	task automatic t_stack();
		clr();
		for (int i = 1; i <= 10; i++)
			run(ASL_OP_LOAD_WORD, ASL_SRC_CONST, 32'(i));
		chk(stack_top_o, 32'h9);
		for (int i = 0; i < 9; i++)
		begin
			run(ASL_OP_POP, ASL_SRC_MEM, 32'h0);
			chk(acc_o, (i < 8) ? 32'(9 - i) : 32'h0);
		end
		clr();
		$display("stack done");
	endtask
	initial
	begin
		rst_i = 1'b1;
		scan_end_i = 1'b0;
		start_i = 1'b0;
		op_i = ASL_OP_LOAD_WORD;
		src_i = ASL_SRC_MEM;
		addr_i = 16'h0;
		const_i = 32'h0;
		bit_addr_i = 16'h0;
		bit_count_i = 6'h1;
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		t_load_push();
		t_out();
		t_double();
		t_ptr();
		t_bits_octal();
		t_stack();
		summarize();
	end
endmodule
